// ### common/gpio_query_pkg.sv
// Constants, field positions, reset values and carrier types of the pin query and settings block.
package gpio_query_pkg;

	// ------------------------------------------------------------------
	// Command and response codes
	// ------------------------------------------------------------------
	localparam logic [7:0] CMD_QUERY = 8'h51;
	localparam logic [7:0] CMD_SETTINGS = 8'h60;
	localparam logic [7:0] RESP_OK = 8'h00;
	localparam logic [7:0] RESP_UNKNOWN = 8'hFF;
	localparam logic [7:0] LEVEL_NOT_GPIO = 8'hEE;
	localparam logic [7:0] DIR_NOT_GPIO = 8'hEF;

	// ------------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] CMD_BASE = 8'h00;
	localparam logic [7:0] RESP_BASE = 8'h40;
	localparam logic [7:0] CTRL_OFF = 8'h80;
	localparam logic [7:0] STATUS_OFF = 8'h84;
	localparam logic [7:0] CONFIG_OFF = 8'h88;
	localparam logic [7:0] SETTINGS_OFF = 8'h8C;
	localparam int PKT_WORDS = 16;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int LOAD_EN_BIT = 7;
	localparam int DIV_LSB = 0;
	localparam int DUTY_LSB = 3;
	localparam int LEVEL_LSB = 1;
	localparam int SRC_BIT = 0;
	localparam int DAC_LSB = 0;
	localparam int CTRL_START_BIT = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_UNKNOWN_BIT = 2;
	localparam int CONFIG_DIR_LSB = 4;
	localparam int PRESCALE_W = 7;

	// ------------------------------------------------------------------
	// Types and reset values
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [4:0] dac;
		logic ref_internal;
		logic [1:0] ref_level;
		logic [1:0] duty;
		logic [2:0] div;
	} settings_t;

	typedef struct packed {
		logic [3:0][7:0] dir_byte;
		logic [3:0][7:0] level_byte;
	} pin_report_t;

	typedef enum logic [0:0] {
		st_idle = 1'b0,
		st_exec = 1'b1
	} state_t;

	localparam settings_t SETTINGS_DEFAULT = '{dac: 5'h00, ref_internal: 1'h0,
		ref_level: 2'h0, duty: 2'h2, div: 3'h1};
	localparam logic [3:0] DEF_GPIO_EN = 4'h0;
	localparam logic [3:0] DEF_DIR_INPUT = 4'hF;

endpackage

// ### hdl/pin_report.sv
// Encodes the level and direction bytes of the four general pins for the query reply.
`timescale 1ns/10ps
module pin_report
	import gpio_query_pkg::*;
(
	input wire logic [3:0] pin_is_gpio,
	input wire logic [3:0] pin_is_input,
	input wire logic [3:0] pin_level,
	output pin_report_t report
);

	logic [3:0][7:0] level_b;
	logic [3:0][7:0] dir_b;

	for (genvar i = 0; i < 4; i++) begin : g_pin
		assign level_b[i] = pin_is_gpio[i] ? {7'h00, pin_level[i]} : LEVEL_NOT_GPIO;
		assign dir_b[i] = pin_is_gpio[i] ? {7'h00, pin_is_input[i]} : DIR_NOT_GPIO;
	end

	assign report = '{dir_byte: dir_b, level_byte: level_b};

endmodule // pin_report

// ### hdl/clk_ref_gen.sv
// Reference clock output with a power-of-two divider and a four-step duty cycle.
`timescale 1ns/10ps
module clk_ref_gen
	import gpio_query_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [2:0] div_req,
	input wire logic [1:0] duty_req,
	output logic clk_ref_out
);

	logic [PRESCALE_W-1:0] pre_q;
	logic [1:0] phase_q;
	logic [2:0] div_q;
	logic [1:0] duty_q;
	logic out_q;
	logic [7:0] span;
	logic [PRESCALE_W-1:0] limit;
	logic tick;
	logic wrap;

	// The output period is four phases of 2^div system clocks each.
	assign span = 8'h01 << div_q;
	assign limit = PRESCALE_W'(span - 8'h01);
	assign tick = (pre_q == limit);
	assign wrap = tick && (phase_q == 2'h3);

	// New settings are taken only at the end of a whole period, so no runt pulse appears.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pre_q <= '0;
			phase_q <= 2'h0;
			div_q <= SETTINGS_DEFAULT.div;
			duty_q <= SETTINGS_DEFAULT.duty;
			out_q <= 1'h0;
		end else begin
			pre_q <= tick ? '0 : PRESCALE_W'(pre_q + 1'h1);
			phase_q <= tick ? 2'(phase_q + 2'h1) : phase_q;
			if (wrap) begin
				div_q <= div_req;
				duty_q <= duty_req;
			end
			out_q <= (phase_q < duty_q);
		end
	end

	assign clk_ref_out = out_q;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	gen_hold_a: assert property (!wrap |=> $stable(div_q) && $stable(duty_q))
		else $error("Reference clock settings changed inside a period.");
	duty_zero_a: assert property (duty_q == 2'h0 |=> !clk_ref_out)
		else $error("Zero duty cycle drove the clock output high.");
	duty_high_a: assert property ((duty_q == 2'h3 && phase_q == 2'h2) |=> clk_ref_out)
		else $error("Three quarter duty cycle missed its third high phase.");

endmodule // clk_ref_gen

// ### hdl/gpio_query_and_runtime_settings.sv
// Wishbone slave that runs pin query and run-time settings command packets.
// ------------------------------------------------------------------
// Summary of operation
// - Command code 0x51 queries all GPIO pins; bytes 1 to 63 are ignored.
// - Query reply echoes the code in byte 0 and puts 0x00 in byte 1.
// - Reply bytes 2,4,6,8 give pin levels 0 to 3, or 0xEE if not GPIO.
// - Reply bytes 3,5,7,9 give directions, 0 output 1 input, or 0xEF.
// - Command code 0x60 updates run-time settings; byte 1 is ignored.
// - Settings live in volatile registers only and revert at reset.
// - Byte 2 bit 7 loads divider bits 2-0 and duty; else unchanged.
// - Byte 2 bits 4-3 pick duty 0, 25, 50 or 75 percent.
// - Byte 3 bit 7 loads reference selection bits 2-0; else kept.
// - Byte 3 bits 2-1 pick internal reference level or off.
// - Byte 3 bit 0 picks internal reference or supply rail.
// - Byte 4 bit 7 loads five-bit converter code; else kept.
// ------------------------------------------------------------------
//
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
module gpio_query_and_runtime_settings
	import gpio_query_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [3:0] pin_level,
	output logic [3:0] pin_is_gpio,
	output logic [3:0] pin_is_input,
	output logic clk_ref_out,
	output logic [1:0] internal_reference_level,
	output logic ref_internal,
	output logic [4:0] dac_code
);

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	function automatic logic hits(input logic [7:0] adr, input logic [7:0] off);
		hits = (adr[7:2] == off[7:2]);
	endfunction

	logic req;
	logic ack_q;
	logic wr_fire;
	logic in_cmd;
	logic in_resp;
	logic [3:0] word_idx;
	logic hit_ctrl;
	logic hit_status;
	logic hit_config;
	logic hit_settings;

	assign req = wb_cyc_i && wb_stb_i;
	assign wr_fire = req && wb_we_i && ack_q;
	assign in_cmd = (wb_adr_i[7:6] == CMD_BASE[7:6]);
	assign in_resp = (wb_adr_i[7:6] == RESP_BASE[7:6]);
	assign word_idx = wb_adr_i[5:2];
	assign hit_ctrl = hits(wb_adr_i, CTRL_OFF);
	assign hit_status = hits(wb_adr_i, STATUS_OFF);
	assign hit_config = hits(wb_adr_i, CONFIG_OFF);
	assign hit_settings = hits(wb_adr_i, SETTINGS_OFF);

	// ------------------------------------------------------------------
	// Packet memories and control state
	// ------------------------------------------------------------------
	logic [31:0] cmd_mem [PKT_WORDS];
	logic [31:0] resp_mem [PKT_WORDS];
	logic [31:0] resp_next [PKT_WORDS];
	state_t state_q;
	logic done_q;
	logic unknown_q;
	logic [3:0] gpio_q;
	logic [3:0] dir_q;
	settings_t set_q;
	logic [31:0] rd_q;

	// ------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------
	logic [7:0] code;
	logic [7:0] clk_byte;
	logic [7:0] ref_byte;
	logic [7:0] dac_byte;
	logic exec;
	logic is_query;
	logic is_settings;
	logic start;
	logic done_clr;
	logic load_clk;
	logic load_ref;
	logic load_dac;
	pin_report_t report;

	// Only byte 0 selects the command; the query never looks at bytes 1 to 63.
	assign code = cmd_mem[0][7:0];
	assign clk_byte = cmd_mem[0][23:16];
	assign ref_byte = cmd_mem[0][31:24];
	assign dac_byte = cmd_mem[1][7:0];
	assign exec = (state_q == st_exec);
	assign is_query = (code == CMD_QUERY);
	assign is_settings = (code == CMD_SETTINGS);
	assign start = wr_fire && hit_ctrl && wb_dat_i[CTRL_START_BIT] && (state_q == st_idle);
	assign done_clr = wr_fire && hit_status && wb_dat_i[STAT_DONE_BIT];
	assign load_clk = exec && is_settings && clk_byte[LOAD_EN_BIT];
	assign load_ref = exec && is_settings && ref_byte[LOAD_EN_BIT];
	assign load_dac = exec && is_settings && dac_byte[LOAD_EN_BIT];

	pin_report u_pin_report (
		.pin_is_gpio(gpio_q),
		.pin_is_input(dir_q),
		.pin_level(pin_level),
		.report(report)
	);

	// ------------------------------------------------------------------
	// Response assembly
	// ------------------------------------------------------------------
	logic [31:0] word0_next;
	logic [31:0] word1_next;
	logic [31:0] word2_next;
	logic [31:0] w0_query;
	logic [31:0] w0_other;

	assign w0_query = {report.dir_byte[0], report.level_byte[0], RESP_OK, CMD_QUERY};
	assign w0_other = {16'h0000, (is_settings ? RESP_OK : RESP_UNKNOWN), code};
	assign word0_next = is_query ? w0_query : w0_other;
	assign word1_next = is_query ? {report.dir_byte[2], report.level_byte[2],
		report.dir_byte[1], report.level_byte[1]} : 32'h0000_0000;
	assign word2_next = is_query ? {16'h0000, report.dir_byte[3], report.level_byte[3]}
		: 32'h0000_0000;

	for (genvar i = 0; i < PKT_WORDS; i++) begin : g_resp
		assign resp_next[i] = (i == 0) ? word0_next : (i == 1) ? word1_next :
			(i == 2) ? word2_next : 32'h0000_0000;
	end

	// ------------------------------------------------------------------
	// Read multiplexer
	// ------------------------------------------------------------------
	logic [31:0] status_word;
	logic [31:0] config_word;
	logic [31:0] settings_word;
	logic [31:0] rd_mux;

	assign status_word = {29'h0000_0000, unknown_q, done_q, exec};
	assign config_word = {24'h00_0000, dir_q, gpio_q};
	assign settings_word = {19'h0_0000, set_q};
	assign rd_mux = in_cmd ? cmd_mem[word_idx] :
		in_resp ? resp_mem[word_idx] :
		hit_status ? status_word :
		hit_config ? config_word :
		hit_settings ? settings_word : 32'h0000_0000;

	// ------------------------------------------------------------------
	// Bus handshake
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_q <= 1'h0;
			rd_q <= 32'h0000_0000;
		end else begin
			ack_q <= req && !ack_q;
			if (req && !ack_q) begin
				rd_q <= rd_mux;
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rd_q;

	// ------------------------------------------------------------------
	// Command buffer writes
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int w = 0; w < PKT_WORDS; w++) begin
				cmd_mem[w] <= 32'h0000_0000;
			end
		end else if (wr_fire && in_cmd) begin
			for (int b = 0; b < 4; b++) begin
				if (wb_sel_i[b]) begin
					cmd_mem[word_idx][8*b +: 8] <= wb_dat_i[8*b +: 8];
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Sequencer and response store
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= st_idle;
			for (int w = 0; w < PKT_WORDS; w++) begin
				resp_mem[w] <= 32'h0000_0000;
			end
		end else begin
			case (state_q)
				st_idle: begin
					if (start) begin
						state_q <= st_exec;
					end
				end
				st_exec: begin
					for (int w = 0; w < PKT_WORDS; w++) begin
						resp_mem[w] <= resp_next[w];
					end
					state_q <= st_idle;
				end
				default: begin
					state_q <= st_idle;
				end
			endcase
		end
	end

	// Completion wins over a clear written in the same cycle.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			done_q <= 1'h0;
			unknown_q <= 1'h0;
		end else begin
			done_q <= exec || (done_q && !done_clr);
			if (exec) begin
				unknown_q <= !(is_query || is_settings);
			end
		end
	end

	// ------------------------------------------------------------------
	// Pin configuration and volatile settings
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			gpio_q <= DEF_GPIO_EN;
			dir_q <= DEF_DIR_INPUT;
		end else if (wr_fire && hit_config && wb_sel_i[0]) begin
			gpio_q <= wb_dat_i[3:0];
			dir_q <= wb_dat_i[CONFIG_DIR_LSB +: 4];
		end
	end

	// Defaults are constants; a command only ever changes the working copy.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			set_q <= SETTINGS_DEFAULT;
		end else begin
			if (load_clk) begin
				set_q.div <= clk_byte[DIV_LSB +: 3];
				set_q.duty <= clk_byte[DUTY_LSB +: 2];
			end
			if (load_ref) begin
				set_q.ref_level <= ref_byte[LEVEL_LSB +: 2];
				set_q.ref_internal <= ref_byte[SRC_BIT];
			end
			if (load_dac) begin
				set_q.dac <= dac_byte[DAC_LSB +: 5];
			end
		end
	end

	clk_ref_gen u_clk_ref_gen (
		.clk(clk),
		.rstn(rstn),
		.div_req(set_q.div),
		.duty_req(set_q.duty),
		.clk_ref_out(clk_ref_out)
	);

	assign pin_is_gpio = gpio_q;
	assign pin_is_input = dir_q;
	assign internal_reference_level = set_q.ref_level;
	assign ref_internal = set_q.ref_internal;
	assign dac_code = set_q.dac;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence exec_query;
		exec && is_query;
	endsequence

	sequence exec_settings;
		exec && is_settings;
	endsequence

	query_echo_a: assert property (exec_query |=> resp_mem[0][15:0] == 16'h0051)
		else $error("Query reply lacks echo or success byte.");
	level_rep_a: assert property (exec_query |=> resp_mem[0][23:16] ==
		($past(gpio_q[0]) ? {7'h00, $past(pin_level[0])} : 8'hEE))
		else $error("Pin zero level byte is wrong.");
	dir_rep_a: assert property (exec_query |=> resp_mem[2][15:8] ==
		($past(gpio_q[3]) ? {7'h00, $past(dir_q[3])} : 8'hEF))
		else $error("Pin three direction byte is wrong.");
	resp_zero_a: assert property (exec_query |=> resp_mem[2][31:16] == 16'h0000
		&& resp_mem[15] == 32'h0000_0000)
		else $error("Unused reply bytes are not zero.");
	settings_echo_a: assert property (exec_settings |=> resp_mem[0][15:0] == 16'h0060)
		else $error("Settings reply lacks echo or success byte.");
	clk_load_a: assert property ((exec_settings and clk_byte[7]) |=>
		set_q.div == $past(clk_byte[2:0]) && set_q.duty == $past(clk_byte[4:3]))
		else $error("Clock divider or duty not loaded.");
	clk_hold_a: assert property (!load_clk |=> $stable(set_q.div) && $stable(set_q.duty))
		else $error("Clock setting changed without its enable bit.");
	ref_load_a: assert property ((exec_settings and ref_byte[7]) |=>
		{internal_reference_level, ref_internal} == $past(ref_byte[2:0]))
		else $error("Reference selection not loaded.");
	dac_keep_a: assert property ((exec_settings and !dac_byte[7]) |=> $stable(dac_code))
		else $error("Converter code changed with its enable bit clear.");
	dac_load_a: assert property ((exec_settings and dac_byte[7]) |=>
		dac_code == $past(dac_byte[4:0]))
		else $error("Converter code not loaded.");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("Bus acknowledge held longer than one cycle.");
	run_done_a: assert property (start |=> exec ##1 (done_q && !exec))
		else $error("Command did not complete in one cycle.");

endmodule // gpio_query_and_runtime_settings

// ### tb/pin_partner.sv
// Far-side model of the four general pins.
`timescale 1ns/10ps
module pin_partner (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] lvl_req,
	output logic [3:0] pin_level
);
	// Levels move only just after a rising edge, like a synchronised pin.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_level <= 4'h0;
		end else begin
			pin_level <= lvl_req;
		end
	end
endmodule // pin_partner

// ### tb/tb.sv
// Self-checking bench for the pin query and run-time settings block.
`timescale 1ns/10ps
module tb;
	import gpio_query_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hF;
	logic [31:0] dat_w = 32'h0;
	logic [31:0] dat_r;
	logic ack;
	logic [3:0] lvl_req = 4'h0;
	logic [3:0] pin_level;
	logic [3:0] gpio;
	logic [3:0] inp;
	logic cko;
	logic [1:0] lvl;
	logic rint;
	logic [4:0] dac;
	int err_count = 0;
	int n_checks = 0;
	logic [63:0] exp_q[$];
	settings_t s_exp;
	logic [31:0] rv;
	logic [7:0] pkt[64];
	logic [7:0] cfg;
	logic [2:0] en;
	logic [2:0] d3;
	int cnt;

	always #25 clk = ~clk;

	gpio_query_and_runtime_settings gpio_query_and_runtime_settings_i (.clk(clk), .rstn(rstn),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .pin_level(pin_level),
		.pin_is_gpio(gpio), .pin_is_input(inp), .clk_ref_out(cko),
		.internal_reference_level(lvl), .ref_internal(rint), .dac_code(dac));
	pin_partner pin_partner_i (.clk(clk), .rstn(rstn), .lvl_req(lvl_req), .pin_level(pin_level));

	// ------------------------------------------------------------------
	// Reporting and comparison
	// ------------------------------------------------------------------
	task wrap_up;
		if (err_count == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task cmp_word(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
		n_checks++;
		if ((got & msk) !== (exp & msk)) begin
			err_count++;
			$display("[ERR] %0t read %h expected %h", $time, got, exp);
		end
	endtask

	task cmp_port(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t output %h expected %h", $time, got, exp);
		end
	endtask

	task ports_ok;
		cmp_port({24'h0, lvl, rint, dac}, {24'h0, s_exp.ref_level, s_exp.ref_internal, s_exp.dac});
	endtask

	// The oldest note on the queue belongs to the read being answered now.
	always @(posedge clk) begin
		logic [63:0] e;
		if (ack === 1'b1 && we === 1'b0) begin
			if (exp_q.size() == 0) begin
				err_count++;
				$display("[ERR] %0t read answered with nothing expected", $time);
			end else begin
				e = exp_q.pop_front();
				cmp_word(dat_r, e[31:0], e[63:32]);
			end
		end
	end

	// ------------------------------------------------------------------
	// Wishbone master
	// ------------------------------------------------------------------
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= d;
		for (i = 0; i < 8; i++) begin
			@(posedge clk);
			if (ack === 1'b1) break;
		end
		if (ack !== 1'b1) begin
			err_count++;
			$display("[ERR] %0t no acknowledge", $time);
			wrap_up();
		end
		rv = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
		exp_q.push_back({msk, exp});
		bus(1'b0, a, 32'h0);
	endtask

	// Loads the packet, starts it and waits for completion, then clears done.
	task send(input logic [7:0] code);
		int i;
		pkt[0] = code;
		for (i = 0; i < PKT_WORDS; i++) begin
			bus(1'b1, CMD_BASE + 8'(4 * i), {pkt[4*i+3], pkt[4*i+2], pkt[4*i+1], pkt[4*i]});
		end
		bus(1'b1, CTRL_OFF, 32'h1);
		for (i = 0; i < 20; i++) begin
			rd(STATUS_OFF, 32'h0, 32'hFFFF_FFF8);
			if (rv[STAT_DONE_BIT] === 1'b1) break;
		end
		if (rv[STAT_DONE_BIT] !== 1'b1) begin
			err_count++;
			$display("[ERR] %0t command never completed", $time);
			wrap_up();
		end
		bus(1'b1, STATUS_OFF, 32'h2);
	endtask

	function automatic logic [7:0] qbyte(int k, logic [7:0] c, logic [3:0] l);
		int p;
		p = (k - 2) / 2;
		if (k == 0) return CMD_QUERY;
		if (k < 2 || k > 9) return 8'h00;
		if (c[p] !== 1'b1) return (k % 2 == 0) ? LEVEL_NOT_GPIO : DIR_NOT_GPIO;
		return (k % 2 == 0) ? {7'h0, l[p]} : {7'h0, c[4+p]};
	endfunction

	task rand_pkt;
		foreach (pkt[k]) pkt[k] = 8'($urandom);
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		rv = $urandom(23);
		s_exp = SETTINGS_DEFAULT;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rd(CONFIG_OFF, 32'hF0, 32'hFF);
		rd(SETTINGS_OFF, {19'h0, s_exp}, 32'h1FFF);
		ports_ok();
		for (int t = 0; t < 4; t++) begin
			cfg = 8'($urandom);
			if (t == 0) cfg[3:0] = 4'hF;
			if (t == 1) cfg[3:0] = 4'h0;
			lvl_req <= 4'($urandom);
			bus(1'b1, CONFIG_OFF, {24'h0, cfg});
			rand_pkt();
			send(CMD_QUERY);
			cmp_port({24'h0, inp, gpio}, {24'h0, cfg});
			for (int w = 0; w < PKT_WORDS; w++) begin
				rd(RESP_BASE + 8'(4 * w), {qbyte(4*w+3, cfg, lvl_req), qbyte(4*w+2, cfg, lvl_req),
					qbyte(4*w+1, cfg, lvl_req), qbyte(4*w, cfg, lvl_req)}, '1);
			end
		end
		for (int t = 0; t < 8; t++) begin
			rand_pkt();
			en = (t < 4) ? 3'b111 : 3'($urandom);
			d3 = 3'($urandom_range(2, 0));
			pkt[2] = {en[0], pkt[2][6:5], 2'(t), d3};
			pkt[3] = {en[1], pkt[3][6:3], 2'(t + 1), pkt[3][0]};
			pkt[4][7] = en[2];
			if (en[0]) begin
				s_exp.div = d3;
				s_exp.duty = 2'(t);
			end
			if (en[1]) {s_exp.ref_level, s_exp.ref_internal} = pkt[3][2:0];
			if (en[2]) s_exp.dac = pkt[4][4:0];
			send(CMD_SETTINGS);
			rd(RESP_BASE, 32'h60, '1);
			rd(SETTINGS_OFF, {19'h0, s_exp}, 32'h1FFF);
			ports_ok();
			repeat (40) @(posedge clk);
			cnt = 0;
			repeat (4 << s_exp.div) begin
				@(posedge clk);
				cnt += (cko === 1'b1) ? 1 : 0;
			end
			cmp_port(32'(cnt), 32'(s_exp.duty) << s_exp.div);
		end
		rand_pkt();
		send(8'h33);
		rd(RESP_BASE, 32'h0000FF33, '1);
		rd(STATUS_OFF, 32'h4, 32'h4);
		bus(1'b1, SETTINGS_OFF, '1);
		rd(SETTINGS_OFF, {19'h0, s_exp}, 32'h1FFF);
		bus(1'b1, 8'h90, '1);
		rd(8'h90, 32'h0, '1);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		s_exp = SETTINGS_DEFAULT;
		rd(SETTINGS_OFF, {19'h0, s_exp}, 32'h1FFF);
		ports_ok();
		cmp_port({24'h0, inp, gpio}, {24'h0, DEF_DIR_INPUT, DEF_GPIO_EN});
		wrap_up();
	end
endmodule // tb
